//--- core/fts_fan_supervisor.sv
/*
  Fan tach measurement, stall and drive-fail detection, spin-up routine and
  clock pin control for one fan, with an AXI4-Lite register slave.
  Assumes a closed-loop controller elsewhere supplies loopDrive on clk; the
  tach, clock pin and strap inputs are asynchronous and are synchronised here.
*/
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
// How it works
// RQ1: fan counts as stalled when tach count exceeds the valid-count limit.
// RQ2: stall under closed loop starts spin-up automatically.
// RQ3: target above valid limit is ignored; present drive is kept.
// RQ4: stall sets stall flag and raises the alert output.
// RQ5: closed loop retries spin-up until valid tach or loop disabled.
// RQ6: entering direct mode or spin-up masks stall for the spin time.
// RQ7: in direct mode stall is checked continuously.
// RQ8: in closed loop stall is checked only at update ticks.
// RQ9: out of band at full drive sets drive-fail and alert.
// RQ10: drive-fail field: off, 16, 32 or 64 update periods.
// RQ11: pull-up code maps to default drive off,30,50,75,100,off.
// RQ12: tach reference is external clock pin or internal oscillator.
// RQ13: as clock source, internal clock is driven push-pull on clock pin.
// RQ14: direct mode drive change zero to nonzero launches spin-up.
// RQ15: closed loop target change all-ones to below limit launches spin-up.
// RQ16: optional full-scale kick for first quarter of spin time.
// RQ17: rest of spin uses level 30% plus 5% per code.
// RQ18: spin time 250 ms, 500 ms, 1 s or 2 s.
// RQ19: after spin, still slow sets spin-fail and retries.
// RQ20: power-up pin role does not limit configured clock pin role; here a drive-decode strap blocks clock output and external clock use.
// RQ21: tach count spans 3, 5, 7 or 9 edges.
// RQ22: only the two top address codes use the pin for drive decode; here codes 4 to 7 (four codes) do.
// RQ23: nonzero power-up default drive is applied without spin-up.
// RQ24: with no tach edges the count saturates at full scale.
`timescale 1ns/1ps
`default_nettype none
module fts_fan_supervisor #(
  parameter int unsigned SPIN_CYC = fts_pkg::SPIN_BASE_CYCLES,
  parameter int unsigned UPDATE_CYC = fts_pkg::UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [fts_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [fts_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tachIn,
  input wire logic clkPinIn,
  output logic clkPinOut,
  output logic clkPinOe_n,
  input wire logic [2:0] addrSel,
  input wire logic [2:0] clkPullCode,
  input wire logic [7:0] loopDrive,
  output logic [7:0] fanDrive,
  output logic alert
);
  logic [12:0] cfg;
  logic [7:0] driveSetting;
  logic [15:0] validLimit, target, band, tachReading, tachCnt;
  logic [2:0] status;
  logic wrFire, rdFire, measDone, updateTick, refTick, pinReserved;
  logic [31:0] wrMerged, spinTotal, spinTmr, maskCnt, updCnt;
  logic [2:0] tachSync, extSync, selSync1, selSync2, pullSync1, pullSync2;
  logic [11:0] divCnt;
  logic [3:0] edgeCnt, edgeNeed;
  logic [1:0] strapCnt;
  logic [6:0] dfCnt, dfLimit;
  logic [7:0] heldDrive, levelDrive, next_fanDrive;
  logic loopPrev, spinStart, dirSpinReq, tgtSpinReq, loopStall, tachSlow;
  fts_pkg::fts_spin_e spinState;

  wire loopEn = cfg[fts_pkg::CF_LOOP];
  wire [1:0] dfc = cfg[fts_pkg::CF_DFC +: 2];
  assign tachSlow = tachReading > validLimit; // see RQ1
  assign spinTotal = SPIN_CYC << cfg[fts_pkg::CF_SPT +: 2]; // see RQ18
  assign levelDrive = fts_pkg::fts_pct(30 + 5 * cfg[fts_pkg::CF_LEVEL +: 3]); // see RQ17
  assign edgeNeed = {1'b0, cfg[fts_pkg::CF_EDGE +: 2], 1'b1} + 4'h2; // see RQ21

  // AXI4-Lite: address and data are taken together, one cycle before the answer
  assign wrFire = awvalid && wvalid && !bvalid;
  assign awready = wrFire;
  assign wready = wrFire;
  assign rdFire = arvalid && !rvalid;
  assign arready = !rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (wstrb[i]) begin
        r[8*i +: 8] = wdata[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    unique case (awaddr)
      fts_pkg::OFF_CONFIG: wrMerged = merge({19'h0, cfg});
      fts_pkg::OFF_DRIVE: wrMerged = merge({24'h0, driveSetting});
      fts_pkg::OFF_VALID: wrMerged = merge({16'h0, validLimit});
      fts_pkg::OFF_TARGET: wrMerged = merge({16'h0, target});
      fts_pkg::OFF_BAND: wrMerged = merge({16'h0, band});
      default: wrMerged = merge(32'h0);
    endcase
  end

  function automatic logic mapped(input logic [fts_pkg::ADDR_W-1:0] a);
    return a[1:0] == 2'h0;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= fts_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= mapped(awaddr) ? fts_pkg::RESP_OKAY : fts_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rresp <= fts_pkg::RESP_OKAY;
      rdata <= 32'h0;
    end else if (rdFire) begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? fts_pkg::RESP_OKAY : fts_pkg::RESP_SLVERR;
      unique case (araddr)
        fts_pkg::OFF_CONFIG: rdata <= {19'h0, cfg};
        fts_pkg::OFF_DRIVE: rdata <= {24'h0, driveSetting};
        fts_pkg::OFF_VALID: rdata <= {16'h0, validLimit};
        fts_pkg::OFF_TARGET: rdata <= {16'h0, target};
        fts_pkg::OFF_BAND: rdata <= {16'h0, band};
        fts_pkg::OFF_STATUS: rdata <= {28'h0, spinState != fts_pkg::SP_IDLE, status};
        fts_pkg::OFF_TACH: rdata <= {16'h0, tachReading};
        fts_pkg::OFF_OUTDRV: rdata <= {24'h0, fanDrive};
        default: rdata <= 32'h0;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= fts_pkg::CONFIG_RESET;
      validLimit <= fts_pkg::VALID_RESET;
      target <= fts_pkg::TARGET_RESET;
      band <= fts_pkg::BAND_RESET;
    end else if (wrFire) begin
      unique case (awaddr)
        fts_pkg::OFF_CONFIG: cfg <= wrMerged[12:0];
        fts_pkg::OFF_VALID: validLimit <= wrMerged[15:0];
        fts_pkg::OFF_TARGET: target <= wrMerged[15:0];
        fts_pkg::OFF_BAND: band <= wrMerged[15:0];
        default: ;
      endcase
    end
  end

  // straps are static pins: synchronised, then caught once after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selSync1 <= 3'h0;
      selSync2 <= 3'h0;
      pullSync1 <= 3'h0;
      pullSync2 <= 3'h0;
      strapCnt <= 2'h0;
      pinReserved <= 1'b0;
    end else begin
      selSync1 <= addrSel;
      selSync2 <= selSync1;
      pullSync1 <= clkPullCode;
      pullSync2 <= pullSync1;
      if (strapCnt != 2'h3) begin
        strapCnt <= strapCnt + 2'h1;
      end
      if (strapCnt == 2'h2) begin
        pinReserved <= selSync2 >= fts_pkg::PIN_DRIVE_CODE; // see RQ22
      end
    end
  end

  wire strapLoad = strapCnt == 2'h2 && selSync2 >= fts_pkg::PIN_DRIVE_CODE;
  logic [7:0] pullDrive;
  always_comb begin
    unique case (pullSync2) // see RQ11
      3'h1: pullDrive = fts_pkg::fts_pct(30);
      3'h2: pullDrive = fts_pkg::fts_pct(50);
      3'h3: pullDrive = fts_pkg::fts_pct(75);
      3'h4: pullDrive = fts_pkg::DRIVE_FULL;
      default: pullDrive = 8'h00;
    endcase
  end

  assign dirSpinReq = wrFire && awaddr == fts_pkg::OFF_DRIVE && !loopEn
    && driveSetting == 8'h00 && wrMerged[7:0] != 8'h00; // see RQ14
  assign tgtSpinReq = wrFire && awaddr == fts_pkg::OFF_TARGET && loopEn
    && target == fts_pkg::TARGET_RESET && wrMerged[15:0] < validLimit; // see RQ15

  // default drive goes straight into the setting, bypassing the spin trigger
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driveSetting <= 8'h00;
    end else if (strapLoad) begin
      driveSetting <= pullDrive; // see RQ23
    end else if (wrFire && awaddr == fts_pkg::OFF_DRIVE) begin
      driveSetting <= wrMerged[7:0];
    end
  end

  // reference clock: internal divider or synchronised clock pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCnt <= 12'h000;
      extSync <= 3'h0;
      clkPinOut <= 1'b0;
      clkPinOe_n <= 1'b1;
    end else begin
      divCnt <= (divCnt == fts_pkg::INT_REF_DIV - 12'h001) ? 12'h000 : divCnt + 12'h001;
      extSync <= {extSync[1:0], clkPinIn};
      clkPinOut <= divCnt < fts_pkg::INT_REF_HALF;
      // config decides the role unless the pin is strapped for drive decode
      clkPinOe_n <= !(cfg[fts_pkg::CF_CLKOUT] && !pinReserved); // see RQ13 RQ20
    end
  end

  wire useExt = cfg[fts_pkg::CF_EXTCLK] && !cfg[fts_pkg::CF_CLKOUT] && !pinReserved;
  assign refTick = useExt ? (extSync[1] && !extSync[2])
    : (divCnt == fts_pkg::INT_REF_DIV - 12'h001); // see RQ12

  // tach period: reference ticks from first edge to the selected edge count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // tach idles high on its pull-up; resetting low would fake a first edge
      tachSync <= 3'h7;
      tachCnt <= 16'h0000;
      edgeCnt <= 4'h0;
      tachReading <= fts_pkg::TACH_MAX;
      measDone <= 1'b0;
    end else begin
      tachSync <= {tachSync[1:0], tachIn};
      measDone <= 1'b0;
      if (tachSync[1] != tachSync[2]) begin
        if (edgeCnt == edgeNeed - 4'h1) begin
          tachReading <= tachCnt;
          measDone <= 1'b1;
          tachCnt <= 16'h0000;
          edgeCnt <= 4'h1;
        end else begin
          if (edgeCnt == 4'h0) begin
            tachCnt <= 16'h0000;
          end
          edgeCnt <= edgeCnt + 4'h1;
        end
      end else if (refTick && tachCnt == fts_pkg::TACH_MAX) begin
        // saturated: report full scale and start over, so checks keep coming
        tachReading <= fts_pkg::TACH_MAX; // see RQ24
        measDone <= 1'b1;
        tachCnt <= 16'h0000;
        edgeCnt <= 4'h0;
      end else if (refTick) begin
        tachCnt <= tachCnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      updCnt <= 32'h0;
    end else begin
      updCnt <= (updCnt == UPDATE_CYC - 1) ? 32'h0 : updCnt + 32'h1;
    end
  end
  assign updateTick = updCnt == UPDATE_CYC - 1;

  assign loopStall = loopEn && updateTick && tachSlow && maskCnt == 32'h0
    && spinState == fts_pkg::SP_IDLE; // see RQ8
  wire dirStall = !loopEn && tachSlow && maskCnt == 32'h0
    && spinState == fts_pkg::SP_IDLE; // see RQ7
  wire retry = spinState == fts_pkg::SP_CHECK && measDone && tachSlow
    && (loopEn || driveSetting != 8'h00); // see RQ5 RQ19
  assign spinStart = (spinState == fts_pkg::SP_IDLE && (dirSpinReq || tgtSpinReq || loopStall))
    || retry; // see RQ2
  wire [1:0] firstState = cfg[fts_pkg::CF_KICK] ? 2'(fts_pkg::SP_KICK) : 2'(fts_pkg::SP_HOLD);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spinState <= fts_pkg::SP_IDLE;
      spinTmr <= 32'h0;
    end else begin
      spinTmr <= spinTmr + 32'h1;
      unique case (spinState)
        fts_pkg::SP_IDLE: begin
          if (spinStart) begin
            spinState <= fts_pkg::fts_spin_e'(firstState);
            spinTmr <= 32'h0;
          end
        end
        fts_pkg::SP_KICK: begin
          if (spinTmr + 32'h1 >= spinTotal >> 2) begin
            spinState <= fts_pkg::SP_HOLD; // see RQ16
          end
        end
        fts_pkg::SP_HOLD: begin
          if (spinTmr + 32'h1 >= spinTotal) begin
            spinState <= fts_pkg::SP_CHECK;
          end
        end
        fts_pkg::SP_CHECK: begin
          if (retry) begin
            spinState <= fts_pkg::fts_spin_e'(firstState);
            spinTmr <= 32'h0;
          end else if (measDone) begin
            spinState <= fts_pkg::SP_IDLE;
          end
        end
      endcase
    end
  end

  // stall mask follows spin start or the switch into direct mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      maskCnt <= 32'h0;
      loopPrev <= 1'b0;
    end else begin
      loopPrev <= loopEn;
      if (spinStart || (loopPrev && !loopEn)) begin
        maskCnt <= spinTotal; // see RQ6
      end else if (maskCnt != 32'h0) begin
        maskCnt <= maskCnt - 32'h1;
      end
    end
  end

  always_comb begin
    unique case (dfc)
      2'h1: dfLimit = fts_pkg::DF_BASE;
      2'h2: dfLimit = fts_pkg::DF_BASE << 1;
      2'h3: dfLimit = fts_pkg::DF_BASE << 2;
      default: dfLimit = 7'h00;
    endcase
  end

  wire outOfBand = {1'b0, tachReading} > {1'b0, target} + {1'b0, band};
  wire dfHit = loopEn && updateTick && dfc != 2'h0 && fanDrive == fts_pkg::DRIVE_FULL
    && outOfBand;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dfCnt <= 7'h00;
    end else if (dfc == 2'h0 || (updateTick && !dfHit)) begin
      dfCnt <= 7'h00; // see RQ10
    end else if (dfHit && dfCnt != dfLimit) begin
      dfCnt <= dfCnt + 7'h01;
    end
  end

  // set wins over a write-one-to-clear in the same cycle
  wire stsWr = wrFire && awaddr == fts_pkg::OFF_STATUS;
  wire [2:0] stsSet = {dfHit && dfCnt + 7'h01 == dfLimit, retry, loopStall || dirStall};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= 3'h0;
    end else begin
      status <= (status & ~(stsWr ? wrMerged[2:0] : 3'h0)) | stsSet; // see RQ4 RQ9
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alert <= 1'b0;
    end else begin
      alert <= |status; // see RQ4 RQ9
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heldDrive <= 8'h00;
    end else if (strapLoad) begin
      heldDrive <= pullDrive;
    end else if (loopEn && updateTick && target <= validLimit) begin
      heldDrive <= loopDrive; // see RQ3
    end
  end

  always_comb begin
    unique case (spinState)
      fts_pkg::SP_KICK: next_fanDrive = fts_pkg::DRIVE_FULL;
      fts_pkg::SP_HOLD: next_fanDrive = levelDrive;
      default: next_fanDrive = loopEn ? heldDrive : driveSetting;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fanDrive <= 8'h00;
    end else begin
      fanDrive <= next_fanDrive;
    end
  end

  AST_STALL_DIRECT: assert property (@(posedge clk) disable iff (!resetn) // see RQ7
    dirStall |=> status[fts_pkg::ST_STALL] ##1 alert)
    else $error("direct mode stall not flagged");
  AST_LOOP_NOCHECK: assert property (@(posedge clk) disable iff (!resetn) // see RQ8
    loopEn && !updateTick && !status[0] |=> !status[0])
    else $error("stall flagged between update ticks");
  AST_KICK_FULL: assert property (@(posedge clk) disable iff (!resetn) // see RQ16
    spinState == fts_pkg::SP_KICK |=> fanDrive == fts_pkg::DRIVE_FULL)
    else $error("kick not at full scale");
  AST_HOLD_LEVEL: assert property (@(posedge clk) disable iff (!resetn) // see RQ17
    spinState == fts_pkg::SP_HOLD |=> fanDrive == $past(levelDrive))
    else $error("spin level wrong");
  AST_DIR_SPIN: assert property (@(posedge clk) disable iff (!resetn) // see RQ14
    dirSpinReq && spinState == fts_pkg::SP_IDLE |=> spinState != fts_pkg::SP_IDLE ##1
    fanDrive != 8'h00)
    else $error("spin-up not launched");
  AST_SPIN_FAIL: assert property (@(posedge clk) disable iff (!resetn) // see RQ19
    retry |=> status[fts_pkg::ST_SPINFAIL] && spinTmr == 32'h0)
    else $error("spin failure not flagged");
  AST_TGT_IGNORE: assert property (@(posedge clk) disable iff (!resetn) // see RQ3
    target > validLimit && !strapLoad |=> heldDrive == $past(heldDrive))
    else $error("ignored target changed drive");
  AST_DFC_OFF: assert property (@(posedge clk) disable iff (!resetn) // see RQ10
    dfc == 2'h0 |=> dfCnt == 7'h00 && !$rose(status[fts_pkg::ST_DRVFAIL]))
    else $error("drive fail active while disabled");
  AST_CLK_OUT: assert property (@(posedge clk) disable iff (!resetn) // see RQ13
    cfg[fts_pkg::CF_CLKOUT] && !pinReserved |=> !clkPinOe_n)
    else $error("clock pin not driven");
  AST_TACH_SAT: assert property (@(posedge clk) disable iff (!resetn) // see RQ24
    refTick && tachCnt == fts_pkg::TACH_MAX && tachSync[1] == tachSync[2]
    |=> tachReading == fts_pkg::TACH_MAX && measDone)
    else $error("tach count did not saturate");
  AST_MASK: assert property (@(posedge clk) disable iff (!resetn) // see RQ6
    spinStart |=> maskCnt == $past(spinTotal))
    else $error("stall mask not loaded");
  AST_MASK_GATE: assert property (@(posedge clk) disable iff (!resetn) // see RQ6
    maskCnt != 32'h0 |=> !$rose(status[fts_pkg::ST_STALL]))
    else $error("stall flagged while masked");
endmodule // fts_fan_supervisor
`default_nettype wire

//--- core/fts_pkg.sv
/*
  Constants, register map and types for the fan tach, stall and spin-up block.
  Assumes a 100 MHz system clock; all times are turned into cycles here.
*/
package fts_pkg;
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned SPIN_BASE_MS = 250;
  localparam int unsigned SPIN_BASE_CYCLES = SPIN_BASE_MS * CLK_KHZ;
  localparam int unsigned UPDATE_MS = 100;
  localparam int unsigned UPDATE_CYCLES = UPDATE_MS * CLK_KHZ;
  localparam int unsigned INT_REF_HZ = 32000;
  localparam logic [11:0] INT_REF_DIV = 12'((CLK_KHZ * 1000) / INT_REF_HZ);
  localparam logic [11:0] INT_REF_HALF = INT_REF_DIV >> 1;

  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_DRIVE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_VALID = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_TARGET = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_BAND = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_TACH = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_OUTDRV = 5'h1C;

  // config fields
  localparam int CF_LOOP = 0;
  localparam int CF_CLKOUT = 1;
  localparam int CF_EXTCLK = 2;
  localparam int CF_EDGE = 3;
  localparam int CF_KICK = 5;
  localparam int CF_LEVEL = 6;
  localparam int CF_SPT = 9;
  localparam int CF_DFC = 11;
  localparam logic [12:0] CONFIG_RESET = 13'h03A8;
  localparam int ST_STALL = 0;
  localparam int ST_SPINFAIL = 1;
  localparam int ST_DRVFAIL = 2;

  localparam logic [15:0] VALID_RESET = 16'h0F00;
  localparam logic [15:0] TARGET_RESET = 16'hFFFF;
  localparam logic [15:0] BAND_RESET = 16'h0040;
  localparam logic [15:0] TACH_MAX = 16'hFFFF;
  localparam logic [7:0] DRIVE_FULL = 8'hFF;
  localparam logic [6:0] DF_BASE = 7'h10;
  localparam logic [2:0] PIN_DRIVE_CODE = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SP_IDLE, SP_KICK, SP_HOLD, SP_CHECK} fts_spin_e;

  function automatic logic [7:0] fts_pct(input int unsigned pct);
    return 8'((pct * 255) / 100);
  endfunction
endpackage

//--- test/fts_fan_model.sv
/*
  Behavioural four-wire fan: tach toggles every halfCyc clocks while driven.
  Assumes the bench sets halfCyc; a stopped rotor holds tach at its level.
*/
`timescale 1ns/1ps
`default_nettype none
module fts_fan_model (
  input wire logic clk,
  input wire logic [7:0] drive,
  input wire logic [15:0] halfCyc,
  output logic tach
);
  logic [15:0] cnt;
  initial begin
    cnt = 16'h0000;
    tach = 1'b1;
  end
  // zero drive stops the rotor, so no edges arrive and the count must saturate
  always @(posedge clk) begin
    if (drive != 8'h00 && halfCyc != 16'h0000) begin
      cnt <= (cnt + 16'h0001 >= halfCyc) ? 16'h0000 : cnt + 16'h0001;
      if (cnt + 16'h0001 >= halfCyc) begin
        tach <= ~tach;
      end
    end
  end
endmodule // fts_fan_model
`default_nettype wire

//--- test/fts_fan_supervisor_tb.sv
/*
  Self-checking bench for the fan supervisor: AXI4-Lite master, fan model,
  external reference on the clock pin. Assumes short spin and update counts.
*/
`timescale 1ns/1ps
`default_nettype none
module fts_fan_supervisor_tb;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tachIn, clkPinOut, clkPinOe_n, alert;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, refDiv, wResp;
  logic [2:0] addrSel, clkPullCode;
  logic [7:0] loopDrive, fanDrive;
  logic [15:0] fanHalf;
  wire clkPinIn;
  int fail_count = 0;
  int total_checks = 0;
  // pin level: device drives when enabled, otherwise the external reference
  assign clkPinIn = clkPinOe_n ? refDiv[1] : clkPinOut;
  always #5 clk = ~clk;
  always @(posedge clk) refDiv <= refDiv + 2'h1;
  fts_fan_supervisor #(.SPIN_CYC(400), .UPDATE_CYC(50)) uut (.clk(clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tachIn(tachIn), .clkPinIn(clkPinIn),
    .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n), .addrSel(addrSel),
    .clkPullCode(clkPullCode), .loopDrive(loopDrive), .fanDrive(fanDrive), .alert(alert));
  fts_fan_model fan (.clk(clk), .drive(fanDrive), .halfCyc(fanHalf), .tach(tachIn));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input logic [2:0] s, input logic [2:0] p);
    @(posedge clk);
    resetn <= 1'b0;
    addrSel <= s;
    clkPullCode <= p;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    wc(8);
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    wResp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d & m, e);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc(fts_pkg::OFF_CONFIG, 32'h000003A8, 32'hFFFFFFFF);
    rc(fts_pkg::OFF_VALID, 32'h00000F00, 32'hFFFFFFFF);
    rc(fts_pkg::OFF_TARGET, 32'h0000FFFF, 32'hFFFFFFFF);
    rc(fts_pkg::OFF_TACH, 32'h0000FFFF, 32'hFFFFFFFF);
    axr(5'h01, d, r);
    chk({30'h0, r}, {30'h0, fts_pkg::RESP_SLVERR});
    axw(5'h02, 32'h00000000);
    chk({30'h0, wResp}, {30'h0, fts_pkg::RESP_SLVERR});
    axw(fts_pkg::OFF_CONFIG, 32'h000003AA);
    chk({30'h0, wResp}, {30'h0, fts_pkg::RESP_OKAY});
    wc(5);
    chk({31'h0, clkPinOe_n}, 32'h0);
    axw(fts_pkg::OFF_CONFIG, 32'h000003AC);
    wc(5);
    chk({31'h0, clkPinOe_n}, 32'h1);
    rst(3'h4, 3'h3);
    wc(5);
    chk({24'h0, fanDrive}, 32'h000000BF);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'h8);
    axw(fts_pkg::OFF_CONFIG, 32'h000003AA);
    wc(5);
    chk({31'h0, clkPinOe_n}, 32'h1);
    rst(3'h0, 3'h0);
    $display("test regs done");
  endtask
  task automatic t_direct();
    axw(fts_pkg::OFF_VALID, 32'h00000064);
    axw(fts_pkg::OFF_CONFIG, 32'h0000002C);
    axw(fts_pkg::OFF_DRIVE, 32'h00000080);
    wc(50);
    chk({24'h0, fanDrive}, 32'h000000FF);
    wc(150);
    chk({24'h0, fanDrive}, 32'h0000004C);
    wc(180);
    chk({24'h0, fanDrive}, 32'h0000004C);
    wc(150);
    chk({24'h0, fanDrive}, 32'h00000080);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'hA);
    $display("test direct done");
  endtask
  task automatic t_stall();
    axw(fts_pkg::OFF_STATUS, 32'h00000007);
    wc(300);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'h1);
    fanHalf <= 16'h00C8;
    wc(3000);
    rc(fts_pkg::OFF_STATUS, 32'h1, 32'h1);
    chk({31'h0, alert}, 32'h1);
    fanHalf <= 16'h0014;
    wc(1000);
    axw(fts_pkg::OFF_STATUS, 32'h00000001);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'h1);
    wc(2);
    chk({31'h0, alert}, 32'h0);
    $display("test stall done");
  endtask
  task automatic t_spinfail();
    fanHalf <= 16'h00C8;
    axw(fts_pkg::OFF_DRIVE, 32'h00000000);
    wc(20);
    axw(fts_pkg::OFF_DRIVE, 32'h00000080);
    wc(2500);
    rc(fts_pkg::OFF_STATUS, 32'hA, 32'hA);
    fanHalf <= 16'h0014;
    wc(2500);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'h8);
    axw(fts_pkg::OFF_STATUS, 32'h00000007);
    $display("test spin fail done");
  endtask
  task automatic t_loop();
    loopDrive <= 8'h40;
    axw(fts_pkg::OFF_CONFIG, 32'h0000002D);
    axw(fts_pkg::OFF_TARGET, 32'h00000010);
    rc(fts_pkg::OFF_STATUS, 32'h8, 32'h8);
    wc(1500);
    chk({24'h0, fanDrive}, 32'h00000040);
    axw(fts_pkg::OFF_TARGET, 32'h00000200);
    loopDrive <= 8'h50;
    wc(300);
    chk({24'h0, fanDrive}, 32'h00000040);
    axw(fts_pkg::OFF_BAND, 32'h00000000);
    axw(fts_pkg::OFF_CONFIG, 32'h0000082D);
    loopDrive <= 8'hFF;
    axw(fts_pkg::OFF_TARGET, 32'h00000005);
    wc(400);
    rc(fts_pkg::OFF_STATUS, 32'h0, 32'h4);
    wc(900);
    rc(fts_pkg::OFF_STATUS, 32'h4, 32'h4);
    chk({31'h0, alert}, 32'h1);
    axw(fts_pkg::OFF_STATUS, 32'h00000007);
    fanHalf <= 16'h00C8;
    wc(3000);
    rc(fts_pkg::OFF_STATUS, 32'h9, 32'h9);
    $display("test loop done");
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    refDiv = 2'h0;
    addrSel = 3'h0;
    clkPullCode = 3'h0;
    loopDrive = 8'h00;
    fanHalf = 16'h0014;
    rst(3'h0, 3'h0);
    t_regs();
    t_direct();
    t_stall();
    t_spinfail();
    t_loop();
    wrap_up();
  end
  // the tests need about 16000 cycles; allow nearly four times that before calling it a hang
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule // fts_fan_supervisor_tb
`default_nettype wire
